// file: mpurb_pkg.sv
package mpurb_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] OFS_BASE = 8'h00;
  localparam logic [7:0] OFS_NUMBER = 8'h04;
  localparam logic [7:0] OFS_SIZE = 8'h08;
  localparam logic [7:0] OFS_SPAN = 8'h0c;
  localparam logic [7:0] OFS_LOW = 8'h10;
  // ************************************************************
  // field layout
  // ************************************************************
  localparam int REGION_LSB = 0;
  localparam int REGION_W = 4;
  localparam int VALID_BIT = 4;
  localparam int SIZE_W = 5;
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [4:0] SIZE_FULL = 5'h1f;
  localparam logic [4:0] SIZE_RESET = 5'h04;
  localparam logic [31:0] BASE_RESET = 32'h00000000;
  localparam logic [3:0] REGION_RESET = 4'h0;
  localparam int NUM_REGIONS = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mpurb_bus_t;
endpackage : mpurb_pkg

// file: mpurb_region_base.sv
`timescale 1ns/1ps
module mpurb_region_base #(
  parameter int REGIONS = mpurb_pkg::NUM_REGIONS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [31:0] selSpanLow,
  output logic [32:0] selSpanBytes
);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [4:0] clampSize(input logic [4:0] s);
    clampSize = (s < mpurb_pkg::SIZE_MIN) ? mpurb_pkg::SIZE_MIN : s;
  endfunction : clampSize

  function automatic logic [31:0] alignMask(input logic [4:0] s);
    logic [5:0] n;
    n = {1'b0, s} + 6'h01;
    // lowest base bit at size plus one
    alignMask = (n >= 6'h20) ? 32'h00000000 : (32'hffffffff << n);
  endfunction : alignMask

  function automatic logic [32:0] spanBytes(input logic [4:0] s);
    logic [5:0] n;
    n = {1'b0, s} + 6'h01;
    // size is two to size plus one
    spanBytes = 33'h000000001 << n;
  endfunction : spanBytes

  function automatic logic isWrite(input mpurb_pkg::mpurb_bus_t b, input logic [7:0] ofs);
    isWrite = b.wr && (b.addr == ofs);
  endfunction : isWrite

  mpurb_pkg::mpurb_bus_t bus;
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // ************************************************************
  // state
  // ************************************************************
  logic [3:0] regionNum;
  logic [3:0] next_regionNum;
  logic [31:0] baseMem [REGIONS];
  logic [4:0] sizeMem [REGIONS];
  logic [31:0] next_rdata;
  logic [31:0] next_spanLow;
  logic [32:0] next_spanBytes;
  logic [3:0] target;
  logic baseWr;
  logic sizeWr;
  logic [31:0] next_base;
  logic [4:0] next_size;

  always_comb begin
    next_regionNum = regionNum;
    // valid clear keeps current region as target
    target = regionNum;
    baseWr = isWrite(bus, mpurb_pkg::OFS_BASE);
    sizeWr = isWrite(bus, mpurb_pkg::OFS_SIZE);
    if (baseWr && bus.wdata[mpurb_pkg::VALID_BIT]) begin
      target = bus.wdata[mpurb_pkg::REGION_W-1:0];
      next_regionNum = target;
    end
    // direct region number write
    if (isWrite(bus, mpurb_pkg::OFS_NUMBER)) begin
      next_regionNum = bus.wdata[mpurb_pkg::REGION_W-1:0];
    end
    next_base = bus.wdata & alignMask(sizeMem[target]);
    next_size = clampSize(bus.wdata[mpurb_pkg::SIZE_W-1:0]);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regionNum <= mpurb_pkg::REGION_RESET;
      for (int i = 0; i < REGIONS; i++) begin
        baseMem[i] <= mpurb_pkg::BASE_RESET;
        sizeMem[i] <= mpurb_pkg::SIZE_RESET;
      end
    end else begin
      regionNum <= next_regionNum;
      if (baseWr) begin
        baseMem[target] <= next_base;
      end
      if (sizeWr) begin
        sizeMem[regionNum] <= next_size;
      end
    end
  end

  // ************************************************************
  // read port and selected span
  // ************************************************************
  always_comb begin
    next_spanBytes = spanBytes(sizeMem[regionNum]);
    next_spanLow = (sizeMem[regionNum] == mpurb_pkg::SIZE_FULL) ? 32'h00000000 :
                   (baseMem[regionNum] & alignMask(sizeMem[regionNum]));
    next_rdata = 32'h00000000;
    if (bus.rd) begin
      unique case (bus.addr)
        mpurb_pkg::OFS_BASE: begin
          next_rdata = (next_spanLow & alignMask(mpurb_pkg::SIZE_MIN)) | {28'h0000000, regionNum};
        end
        mpurb_pkg::OFS_NUMBER: next_rdata = {28'h0000000, regionNum};
        mpurb_pkg::OFS_SIZE: next_rdata = {27'h0000000, sizeMem[regionNum]};
        mpurb_pkg::OFS_SPAN: next_rdata = next_spanBytes[31:0];
        mpurb_pkg::OFS_LOW: next_rdata = {31'h00000000, next_spanBytes[32]};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
      selSpanLow <= 32'h00000000;
      selSpanBytes <= 33'h000000020;
    end else begin
      regRdata <= next_rdata;
      selSpanLow <= next_spanLow;
      selSpanBytes <= next_spanBytes;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_valid_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(bus.rd) && ($past(bus.addr) == mpurb_pkg::OFS_BASE) |-> !regRdata[4])
    else $error("valid bit read nonzero");
  chk_region_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    baseWr && bus.wdata[4] |=> regionNum == $past(bus.wdata[3:0]))
    else $error("region number not loaded");
  chk_region_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    baseWr && !bus.wdata[4] |=> regionNum == $past(regionNum))
    else $error("region number changed");
  chk_region_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.rd && bus.addr == mpurb_pkg::OFS_BASE |=> regRdata[3:0] == $past(regionNum))
    else $error("region field wrong");
  chk_full_span: assert property (@(posedge core_clk) disable iff (!rst_n)
    sizeMem[regionNum] == mpurb_pkg::SIZE_FULL |=> selSpanLow == 32'h00000000)
    else $error("full region base nonzero");
  chk_span_bytes: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> selSpanBytes == (33'h000000001 << ($past(sizeMem[regionNum]) + 6'h01)))
    else $error("span bytes wrong");
  chk_size_min: assert property (@(posedge core_clk) disable iff (!rst_n)
    sizeMem[regionNum] >= mpurb_pkg::SIZE_MIN)
    else $error("size below minimum");
  chk_base_align: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> (selSpanLow & ~alignMask($past(sizeMem[regionNum]))) == 32'h00000000)
    else $error("base not aligned");

  // ************************************************************
  // check sequences
  // ************************************************************
  sequence baseWrValid;
    baseWr && bus.wdata[mpurb_pkg::VALID_BIT];
  endsequence

  sequence baseWrPlain;
    baseWr && !bus.wdata[mpurb_pkg::VALID_BIT];
  endsequence

  sequence baseRead;
    bus.rd && (bus.addr == mpurb_pkg::OFS_BASE);
  endsequence

  sequence sizeWrSmall;
    sizeWr && (bus.wdata[mpurb_pkg::SIZE_W-1:0] < mpurb_pkg::SIZE_MIN);
  endsequence
  chk_base_target: assert property (@(posedge core_clk) disable iff (!rst_n)
    baseWrValid |=> baseMem[regionNum] == ($past(bus.wdata) & alignMask(sizeMem[regionNum])))
    else $error("base not stored in new region");
  chk_base_selected: assert property (@(posedge core_clk) disable iff (!rst_n)
    baseWrPlain |=> baseMem[regionNum] == ($past(bus.wdata) & alignMask(sizeMem[regionNum])))
    else $error("base not stored in selected region");
  chk_base_layout: assert property (@(posedge core_clk) disable iff (!rst_n)
    baseRead |=> regRdata[31:5] == selSpanLow[31:5])
    else $error("base field misplaced");
  chk_full_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.rd && (bus.addr == mpurb_pkg::OFS_BASE) && (sizeMem[regionNum] == mpurb_pkg::SIZE_FULL)
    |=> regRdata[31:5] == 27'h0000000)
    else $error("full region base field nonzero");
  chk_field_lsb: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> selSpanLow[$past(sizeMem[regionNum])] == 1'b0)
    else $error("bit below base field set");
  chk_size_clamp: assert property (@(posedge core_clk) disable iff (!rst_n)
    sizeWrSmall |=> sizeMem[regionNum] == mpurb_pkg::SIZE_MIN)
    else $error("small size code not clamped");
  chk_size_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    sizeWr && !(bus.wdata[mpurb_pkg::SIZE_W-1:0] < mpurb_pkg::SIZE_MIN)
    |=> sizeMem[regionNum] == $past(bus.wdata[mpurb_pkg::SIZE_W-1:0]))
    else $error("size code not stored");
  chk_number_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.rd && (bus.addr == mpurb_pkg::OFS_NUMBER) |=> regRdata[3:0] == $past(regionNum))
    else $error("region number readback wrong");
  chk_span_top: assert property (@(posedge core_clk) disable iff (!rst_n)
    sizeMem[regionNum] == mpurb_pkg::SIZE_FULL
    |=> selSpanBytes[32] && (selSpanBytes[31:0] == 32'h00000000))
    else $error("full span bytes wrong");
endmodule : mpurb_region_base

// file: mpurb_region_base_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin failCount++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module mpurb_region_base_test;
  // ************************************************************
  // bench signals
  // ************************************************************
  localparam logic [7:0] BASE = mpurb_pkg::OFS_BASE;
  localparam logic [7:0] NUM = mpurb_pkg::OFS_NUMBER;
  localparam logic [7:0] SIZE = mpurb_pkg::OFS_SIZE;
  localparam logic [7:0] SPL = mpurb_pkg::OFS_SPAN;
  localparam logic [7:0] SPH = mpurb_pkg::OFS_LOW;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] selSpanLow;
  logic [32:0] selSpanBytes;
  int failCount = 0;
  int nCompared = 0;
  always #5 core_clk = ~core_clk;
  mpurb_region_base dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .selSpanLow(selSpanLow),
    .selSpanBytes(selSpanBytes)
  );
  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask : rd
  task automatic span(input logic [31:0] lo, input logic [32:0] by);
    repeat (2) @(posedge core_clk);
    #1 `CHK(selSpanLow, lo)
    `CHK(selSpanBytes, by)
  endtask : span
  task automatic tallyAndFinish;
    if (failCount == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tallyAndFinish
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(NUM, 32'h0);
    rd(SIZE, 32'h4);
    span(32'h0, 33'h20);
    wr(BASE, 32'h00010013);
    rd(NUM, 32'h3);
    rd(BASE, 32'h00010003);
    wr(BASE, 32'h00020007);
    rd(NUM, 32'h3);
    rd(BASE, 32'h00020003);
    wr(NUM, 32'h0);
    rd(BASE, 32'h00000000);
    wr(NUM, 32'h7);
    rd(BASE, 32'h00000007);
    wr(NUM, 32'h3);
    // base field starts at bit size code plus one
    wr(SIZE, 32'h9);
    wr(BASE, 32'h000203e3);
    rd(BASE, 32'h00020003);
    rd(SPL, 32'h400);
    span(32'h00020000, 33'h400);
    wr(SIZE, 32'h1f);
    rd(BASE, 32'h00000003);
    rd(SPL, 32'h0);
    rd(SPH, 32'h1);
    span(32'h0, 33'h100000000);
    wr(SIZE, 32'h2);
    rd(SIZE, 32'h4);
    span(32'h00020000, 33'h20);
    wr(BASE, 32'h00000c13);
    rd(BASE, 32'h00000c03);
    rd(8'h20, 32'h0);
    tallyAndFinish();
  end
  initial begin
    #100000;
    failCount++;
    tallyAndFinish();
  end
endmodule : mpurb_region_base_test
